// ---- rtl/option_regs_defs.vh ----
// Constants for the write-once option register bank.
`ifndef OPTION_REGS_DEFS_VH
`define OPTION_REGS_DEFS_VH
`define ADDR_WIDTH 16
`define ADDR_OPTION_ONE 16'h001e
`define ADDR_OPTION_TWO 16'h001f
`define OPT_RESET_VALUE 8'h00
`define READ_UNMAPPED 8'h00
// Option register one field positions.
`define BIT_CHARGE_PUMP_LOW_VOLTAGE 7
`define BIT_OSCILLATOR_RUN_IN_HALT 6
`define BIT_SERIAL_CLOCK_SOURCE 5
`define BIT_WATCHDOG_RATE_SELECT 4
`define BIT_MONITOR_IN_HALT 3
`define BIT_MONITOR_RESET_DISABLE 2
`define BIT_MONITOR_POWER_DISABLE 1
`define BIT_MONITOR_VOLTAGE_RANGE 0
// Option register two field positions.
`define BIT_SHORT_HALT_RECOVERY 2
`define BIT_HALT_ENABLE 1
`define BIT_WATCHDOG_DISABLE 0
`define OPT_TWO_USED_MASK 8'h07
// Recovery and watchdog timeouts in crystal cycles.
`define RECOVERY_SHORT_CYCLES 13'h0020
`define RECOVERY_LONG_CYCLES 13'h1000
`define WATCHDOG_SHORT_CYCLES 18'h01ff0
`define WATCHDOG_LONG_CYCLES 18'h3fff0
`endif

// ---- rtl/write_once_byte.v ----
// One option byte with its own write-once latch.
`timescale 1ns/10ps
`include "option_regs_defs.vh"
module write_once_byte
(
	// Clock and reset
	input wire core_clk,
	input wire sys_rst,
	// Write side
	input wire write_hit,
	input wire [7:0] write_data,
	// Stored value
	output reg [7:0] value,
	output reg used
);
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			value <= `OPT_RESET_VALUE;
			used <= 1'b0;
		end
		else if (write_hit && !used)
		begin
			value <= write_data;
			used <= 1'b1;
		end
	end
endmodule

// ---- rtl/por_range_bit.v ----
// Voltage range bit cleared only by power-on reset and writable once after it.
`timescale 1ns/10ps
module por_range_bit
(
	// Clock and power-on reset
	input wire core_clk,
	input wire por_rst,
	// Write side
	input wire write_hit,
	input wire write_bit,
	// Stored value
	output reg value
);
	reg used;
	always @(posedge core_clk)
	begin
		if (por_rst)
		begin
			value <= 1'b0;
			used <= 1'b0;
		end
		else if (write_hit && !used)
		begin
			value <= write_bit;
			used <= 1'b1;
		end
	end
endmodule

// ---- rtl/option_registers.v ----
// Write-once option registers and the option signals they drive.
// Notes on behaviour
// - Each option register takes one write after reset; later writes are ignored.
// - Any reset clears every option bit except the voltage range bit.
// - Both registers read back their contents at any time.
// - Registers sit at byte addresses 0x1e and 0x1f.
// - Voltage range bit cleared and re-armed only by power-on reset.
// - Charge-pump low-voltage bit set turns the regulator off.
// - Oscillator-run-in-halt bit set keeps the crystal running in stop.
// - With that bit clear, stop disables the clock generator and its outputs.
// - Serial clock source bit selects bus clock when one, crystal when zero.
// - Watchdog rate bit selects 2^13-16 or 2^18-16 crystal cycles.
// - Monitor works in stop only when powered and monitor-in-halt set.
// - Monitor reset disable bit blocks supply monitor resets.
// - Monitor power disable bit powers the supply monitor down.
// - Voltage range bit selects 5 V mode when one, 3 V when zero.
// - Short recovery bit selects 32 or 4096 crystal cycles for stop exit.
// - Leaving stop through the reset pin always uses the long recovery.
// - Halt enable bit allows stop; clear makes stop an illegal opcode.
// - Watchdog disable bit turns the watchdog off.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "option_regs_defs.vh"
module option_registers
(
	// Clock and resets
	input wire core_clk,
	input wire sys_rst,
	input wire por_rst,
	// Register port
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [7:0] rdata,
	// Processor and system events
	input wire halt_request,
	input wire halt_active,
	input wire halt_exit_by_reset_pin,
	input wire monitor_reset_request,
	// Option outputs
	output wire charge_pump_regulator_on,
	output wire oscillator_run_in_halt,
	output wire clock_generator_enable,
	output wire serial_clock_source,
	output wire watchdog_rate_select,
	output reg [17:0] watchdog_timeout_cycles,
	output wire supply_monitor_powered,
	output wire supply_monitor_active,
	output wire monitor_voltage_range,
	output wire monitor_reset_out,
	output reg [12:0] halt_recovery_cycles,
	output wire halt_accept,
	output wire illegal_opcode_reset,
	output wire watchdog_enable,
	// Write-once latch state
	output wire [1:0] write_used
);
	// ***************************************************
	// Address decode
	// ***************************************************
	function [1:0] decode;
		input [15:0] a;
		begin
			decode = {a == `ADDR_OPTION_TWO, a == `ADDR_OPTION_ONE};
		end
	endfunction

	wire [1:0] wr_hit;
	wire [1:0] rd_hit;
	wire [7:0] option_register_one_raw;
	wire [7:0] option_register_two_raw;
	wire [7:0] option_register_one;
	wire [7:0] option_register_two;
	wire range_value;

	assign wr_hit = wr_en ? decode(addr) : 2'b00;
	assign rd_hit = rd_en ? decode(addr) : 2'b00;

	// ***************************************************
	// Storage
	// ***************************************************
	// Separate latches keep one register's write from blocking the other.
	write_once_byte u_one
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.write_hit(wr_hit[0]),
		.write_data(wdata),
		.value(option_register_one_raw),
		.used(write_used[0])
	);

	write_once_byte u_two
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.write_hit(wr_hit[1]),
		.write_data(wdata & `OPT_TWO_USED_MASK),
		.value(option_register_two_raw),
		.used(write_used[1])
	);

	por_range_bit u_range
	(
		.core_clk(core_clk),
		.por_rst(por_rst),
		.write_hit(wr_hit[0]),
		.write_bit(wdata[`BIT_MONITOR_VOLTAGE_RANGE]),
		.value(range_value)
	);

	assign option_register_one = {option_register_one_raw[7:1], range_value};
	assign option_register_two = option_register_two_raw;

	// ***************************************************
	// Read port
	// ***************************************************
	always @(posedge core_clk)
	begin
		if (sys_rst)
			rdata <= `READ_UNMAPPED;
		else if (rd_hit[0])
			rdata <= option_register_one;
		else if (rd_hit[1])
			rdata <= option_register_two;
		else
			rdata <= `READ_UNMAPPED;
	end

	// ***************************************************
	// Option signals
	// ***************************************************
	assign charge_pump_regulator_on = ~option_register_one[`BIT_CHARGE_PUMP_LOW_VOLTAGE];
	assign oscillator_run_in_halt = option_register_one[`BIT_OSCILLATOR_RUN_IN_HALT];
	assign clock_generator_enable = ~halt_active | oscillator_run_in_halt;
	assign serial_clock_source = option_register_one[`BIT_SERIAL_CLOCK_SOURCE];
	assign watchdog_rate_select = option_register_one[`BIT_WATCHDOG_RATE_SELECT];
	assign supply_monitor_powered = ~option_register_one[`BIT_MONITOR_POWER_DISABLE];
	assign supply_monitor_active = supply_monitor_powered
		& (~halt_active | option_register_one[`BIT_MONITOR_IN_HALT]);
	assign monitor_voltage_range = option_register_one[`BIT_MONITOR_VOLTAGE_RANGE];
	assign monitor_reset_out = monitor_reset_request
		& ~option_register_one[`BIT_MONITOR_RESET_DISABLE];
	assign halt_accept = halt_request & option_register_two[`BIT_HALT_ENABLE];
	assign illegal_opcode_reset = halt_request & ~option_register_two[`BIT_HALT_ENABLE];
	assign watchdog_enable = ~option_register_two[`BIT_WATCHDOG_DISABLE];

	// Count outputs are registered so they settle one cycle after the option.
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			watchdog_timeout_cycles <= `WATCHDOG_LONG_CYCLES;
			halt_recovery_cycles <= `RECOVERY_LONG_CYCLES;
		end
		else
		begin
			watchdog_timeout_cycles <= watchdog_rate_select ?
				`WATCHDOG_SHORT_CYCLES : `WATCHDOG_LONG_CYCLES;
			halt_recovery_cycles <= (option_register_two[`BIT_SHORT_HALT_RECOVERY] && !halt_exit_by_reset_pin) ?
				`RECOVERY_SHORT_CYCLES : `RECOVERY_LONG_CYCLES;
		end
	end
endmodule

// ---- test/option_props.sv ----
// Checker for the write-once option register bank.
`timescale 1ns/10ps
`include "option_regs_defs.vh"
module option_props
(
	// Clock, reset and register port
	input wire core_clk,
	input wire sys_rst,
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] rdata,
	input wire [1:0] write_used,
	// System events and options
	input wire halt_request,
	input wire halt_active,
	input wire halt_exit_by_reset_pin,
	input wire charge_pump_regulator_on,
	input wire oscillator_run_in_halt,
	input wire clock_generator_enable,
	input wire watchdog_rate_select,
	input wire [17:0] watchdog_timeout_cycles,
	input wire supply_monitor_powered,
	input wire supply_monitor_active,
	input wire [12:0] halt_recovery_cycles,
	input wire halt_accept,
	input wire illegal_opcode_reset
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_first;
		wr_en && addr == `ADDR_OPTION_ONE && !write_used[0];
	endsequence
	property p_unmapped;
		rd_en && addr != `ADDR_OPTION_ONE && addr != `ADDR_OPTION_TWO |=> rdata == 8'h00;
	endproperty
	property p_latch;
		s_first |=> write_used[0] && write_used[1] == $past(write_used[1]);
	endproperty
	property p_pump;
		s_first |=> charge_pump_regulator_on == !$past(wdata[7]);
	endproperty
	property p_once;
		wr_en && addr == `ADDR_OPTION_ONE && write_used[0] |=> $stable(charge_pump_regulator_on);
	endproperty
	property p_clk;
		clock_generator_enable == (!halt_active || oscillator_run_in_halt);
	endproperty
	property p_halt;
		halt_request |-> halt_accept != illegal_opcode_reset;
	endproperty
	property p_wdt;
		watchdog_timeout_cycles == ($past(watchdog_rate_select) ? `WATCHDOG_SHORT_CYCLES : `WATCHDOG_LONG_CYCLES);
	endproperty
	property p_rec;
		halt_exit_by_reset_pin |=> halt_recovery_cycles == `RECOVERY_LONG_CYCLES;
	endproperty
	property p_mon;
		halt_active && !supply_monitor_powered |-> !supply_monitor_active;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_latch: assert property (p_latch) else $error("latch wrong after first write");
	a_pump: assert property (p_pump) else $error("regulator does not follow write");
	a_once: assert property (p_once) else $error("second write took effect");
	a_clk: assert property (p_clk) else $error("clock generator enable wrong");
	a_halt: assert property (p_halt) else $error("stop both taken and refused");
	a_wdt: assert property (p_wdt) else $error("watchdog timeout wrong");
	a_rec: assert property (p_rec) else $error("recovery not long");
	a_mon: assert property (p_mon) else $error("monitor active while off");
endmodule

// ---- test/option_registers_tb_top.sv ----
// Self-checking bench for the write-once option register bank.
`timescale 1ns/10ps
module option_registers_tb_top;
	logic core_clk = 0, sys_rst = 1, por_rst = 1, wr_en = 0, rd_en = 0;
	logic halt_request = 0, halt_active = 0, halt_exit_by_reset_pin = 0, monitor_reset_request = 0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	wire [7:0] rdata;
	wire [17:0] wto;
	wire [12:0] rec;
	wire [1:0] used;
	wire pump, osc, cge, sclk, rate, mpow, mact, rng, mrst, hacc, ill, wen;
	int errors = 0, checks = 0, cyc = 0;
	option_registers dut (.core_clk(core_clk), .sys_rst(sys_rst), .por_rst(por_rst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .halt_request(halt_request), .halt_active(halt_active),
		.halt_exit_by_reset_pin(halt_exit_by_reset_pin), .monitor_reset_request(monitor_reset_request),
		.charge_pump_regulator_on(pump), .oscillator_run_in_halt(osc), .clock_generator_enable(cge),
		.serial_clock_source(sclk), .watchdog_rate_select(rate), .watchdog_timeout_cycles(wto),
		.supply_monitor_powered(mpow), .supply_monitor_active(mact), .monitor_voltage_range(rng),
		.monitor_reset_out(mrst), .halt_recovery_cycles(rec), .halt_accept(hacc), .illegal_opcode_reset(ill),
		.watchdog_enable(wen), .write_used(used));
	initial
	begin
		forever #50 core_clk = ~core_clk;
	end
	// ***********************
	// Bus and check tasks
	// ***********************
	task chk(input logic [17:0] s, input logic [17:0] e);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task rst(input logic p);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		por_rst <= p;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge core_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task settle;
		@(posedge core_clk);
		#1;
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 500)
		begin
			errors++;
			end_sim;
		end
	end
	// ***********************
	// Tests
	// ***********************
	initial
	begin
		rst(1'b1);
		rd(16'h001e, 8'h00);
		rd(16'h001f, 8'h00);
		rd(16'h0020, 8'h00);
		wr(16'h001e, 8'ha5);
		wr(16'h001e, 8'h5a);
		wr(16'h001f, 8'hff);
		rd(16'h001e, 8'ha5);
		rd(16'h001f, 8'h07);
		@(posedge core_clk);
		halt_request <= 1'b1;
		halt_active <= 1'b1;
		monitor_reset_request <= 1'b1;
		settle;
		chk(pump, 0);
		chk(sclk, 1);
		chk(wto, 18'h3fff0);
		chk(mpow, 1);
		chk(mact, 0);
		chk(rng, 1);
		chk(mrst, 0);
		chk(cge, 0);
		chk(hacc, 1);
		chk(wen, 0);
		chk(rec, 13'h0020);
		chk(used, 2'h3);
		@(posedge core_clk);
		halt_exit_by_reset_pin <= 1'b1;
		settle;
		chk(rec, 13'h1000);
		$display("test one time done");
		rst(1'b0);
		rd(16'h001e, 8'h01);
		wr(16'h001e, 8'h58);
		settle;
		chk(rate, 1);
		chk(mact, 1);
		chk(cge, 1);
		chk(osc, 1);
		chk(wto, 18'h01ff0);
		chk(ill, 1);
		chk(wen, 1);
		chk(mrst, 1);
		chk(pump, 1);
		chk(sclk, 0);
		rd(16'h001e, 8'h59);
		$display("test warm reset done");
		rst(1'b1);
		rd(16'h001e, 8'h00);
		wr(16'h001e, 8'h0a);
		settle;
		chk(mpow, 0);
		chk(mact, 0);
		$display("test power-on reset done");
		end_sim;
	end
endmodule
bind option_registers option_props chk (.core_clk(core_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .write_used(write_used), .halt_request(halt_request),
	.halt_active(halt_active), .halt_exit_by_reset_pin(halt_exit_by_reset_pin),
	.charge_pump_regulator_on(charge_pump_regulator_on), .oscillator_run_in_halt(oscillator_run_in_halt),
	.clock_generator_enable(clock_generator_enable), .watchdog_rate_select(watchdog_rate_select),
	.watchdog_timeout_cycles(watchdog_timeout_cycles), .supply_monitor_powered(supply_monitor_powered),
	.supply_monitor_active(supply_monitor_active), .halt_recovery_cycles(halt_recovery_cycles),
	.halt_accept(halt_accept), .illegal_opcode_reset(illegal_opcode_reset));
